// ---- hw/csr_pkg.sv ----
// Constants for the CPU stop output reaction block
package csr_pkg;
  localparam int CSR_CHANNELS = 2;
  localparam int CSR_CNT_W = 32;
  localparam logic [1:0] CSR_REACT_SUBST = 2'h0;
  localparam logic [1:0] CSR_REACT_HOLD = 2'h1;
  localparam logic [1:0] CSR_REACT_CONT = 2'h2;
  localparam logic [1:0] CSR_REACT_DEFAULT = 2'h0;
  localparam logic [4:0] CSR_IN_BYTES = 5'h10;
  localparam logic [4:0] CSR_OUT_BYTES_STD = 5'h0C;
  localparam logic [4:0] CSR_OUT_BYTES_MC = 5'h04;
  localparam logic [7:0] CSR_RECORD_PARAM = 8'h80;
  localparam logic [CSR_CNT_W-1:0] CSR_START_DEFAULT = 32'h0000_0000;
  localparam logic [1:0] CSR_SUBST_DEFAULT = 2'h0;
endpackage

// ---- hw/csr_channel.sv ----
// One channel: counter and output reaction to controller stop
`timescale 1ns/10ps
module csr_channel
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic stop_entry,
  input wire logic run_entry,
  input wire logic cpu_stopped,
  input wire logic [1:0] reaction,
  input wire logic [1:0] subst_val,
  input wire logic [csr_pkg::CSR_CNT_W-1:0] start_val,
  input wire logic count_up,
  input wire logic count_dn,
  input wire logic [csr_pkg::CSR_CNT_W-1:0] cmp_val,
  input wire logic [1:0] prog_dq,
  input wire logic [1:0] dq_by_cmp,
  output logic [1:0] dq,
  output logic [csr_pkg::CSR_CNT_W-1:0] count
);
  typedef struct packed {
    logic [csr_pkg::CSR_CNT_W-1:0] cnt;
    logic [1:0] dq;
    logic frozen;
  } csr_ch_state_t;
  csr_ch_state_t st;
  csr_ch_state_t next_st;
  logic [1:0] live_dq;
  always_comb
  begin
    next_st = st;
    live_dq[0] = dq_by_cmp[0] ? (st.cnt >= cmp_val) : prog_dq[0];
    live_dq[1] = dq_by_cmp[1] ? (st.cnt < cmp_val) : prog_dq[1];
    if (count_up && !count_dn)
      next_st.cnt = st.cnt + 1'b1;
    else if (count_dn && !count_up)
      next_st.cnt = st.cnt - 1'b1;
    if (run_entry && reaction != csr_pkg::CSR_REACT_CONT)
    begin
      next_st.cnt = start_val;
      next_st.frozen = 1'b0;
    end
    else if (stop_entry && reaction != csr_pkg::CSR_REACT_CONT)
      next_st.frozen = 1'b1;
    else if (!cpu_stopped)
      next_st.frozen = 1'b0;
    if (next_st.frozen)
    begin
      if (reaction == csr_pkg::CSR_REACT_SUBST)
        next_st.dq = subst_val;
      else
        next_st.dq = st.dq;
    end
    else
      next_st.dq = live_dq;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      st <= '{cnt: csr_pkg::CSR_START_DEFAULT, dq: 2'h0, frozen: 1'b0};
    else
      st <= next_st;
  end
  assign dq = st.dq;
  assign count = st.cnt;
  subst_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    st.frozen && cpu_stopped && reaction == csr_pkg::CSR_REACT_SUBST
    |=> dq == $past(subst_val))
    else $error("substitute value not driven");
  hold_last_a: assert property (@(posedge clk_sys) disable iff (reset)
    st.frozen && cpu_stopped && reaction == csr_pkg::CSR_REACT_HOLD |=> $stable(dq))
    else $error("held output changed");
  restart_cnt_a: assert property (@(posedge clk_sys) disable iff (reset)
    run_entry && reaction != csr_pkg::CSR_REACT_CONT |=> count == $past(start_val))
    else $error("counter not restarted");
  cont_count_a: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_stopped && reaction == csr_pkg::CSR_REACT_CONT && count_up && !count_dn
    |=> count == $past(count) + 1'b1)
    else $error("count stalled in continue mode");
  cont_out_a: assert property (@(posedge clk_sys) disable iff (reset)
    !st.frozen && !stop_entry && !dq_by_cmp[0] |=> dq[0] == $past(prog_dq[0]))
    else $error("output not following program");
endmodule

// ---- hw/csr_top.sv ----
// Stop reaction top: run/stop detect, parameter record, image sizes
`timescale 1ns/10ps
// Operation
// - Continue mode keeps counting pulses while controller is stopped.
// - Substitute mode drives configured output levels until stop-to-run.
// - Hold mode freezes outputs at stop entry until stop-to-run.
// - Substitute and hold restart: counter loads start value, outputs resume.
// - Each channel holds its own stop reaction selection.
// - Normal modes use 16 input bytes and 12 output bytes.
// - Motion position mode uses 16 input bytes and 4 output bytes.
// - Record 128 write replaces all parameters at run time.
// - Parameters not loaded by configuration take defaults until record write.
module csr_top
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cpu_run,
  input wire logic motion_mode,
  input wire logic cfg_load,
  input wire logic cfg_full,
  input wire logic [3:0] cfg_react,
  input wire logic [3:0] cfg_subst,
  input wire logic [63:0] cfg_start,
  input wire logic rec_wr,
  input wire logic [7:0] rec_num,
  input wire logic [3:0] rec_react,
  input wire logic [3:0] rec_subst,
  input wire logic [63:0] rec_start,
  input wire logic [1:0] count_up,
  input wire logic [1:0] count_dn,
  input wire logic [63:0] cmp_val,
  input wire logic [3:0] prog_dq,
  input wire logic [3:0] dq_by_cmp,
  output logic [3:0] dq,
  output logic [63:0] count,
  output logic [4:0] in_bytes,
  output logic [4:0] out_bytes,
  output logic rec_ack
);
  typedef struct packed {
    logic run_q;
    logic stop_ev;
    logic run_ev;
    logic [3:0] react;
    logic [3:0] subst;
    logic [63:0] start;
    logic [4:0] in_b;
    logic [4:0] out_b;
    logic ack;
  } csr_state_t;
  csr_state_t st;
  csr_state_t next_st;
  always_comb
  begin
    next_st = st;
    next_st.run_q = cpu_run;
    next_st.stop_ev = st.run_q && !cpu_run;
    next_st.run_ev = !st.run_q && cpu_run;
    next_st.in_b = csr_pkg::CSR_IN_BYTES;
    next_st.out_b = motion_mode ? csr_pkg::CSR_OUT_BYTES_MC
                                : csr_pkg::CSR_OUT_BYTES_STD;
    next_st.ack = 1'b0;
    if (rec_wr && rec_num == csr_pkg::CSR_RECORD_PARAM)
    begin
      next_st.react = rec_react;
      next_st.subst = rec_subst;
      next_st.start = rec_start;
      next_st.ack = 1'b1;
    end
    else if (cfg_load)
    begin
      next_st.react = cfg_full ? cfg_react
                               : {csr_pkg::CSR_REACT_DEFAULT, csr_pkg::CSR_REACT_DEFAULT};
      next_st.subst = cfg_full ? cfg_subst
                               : {csr_pkg::CSR_SUBST_DEFAULT, csr_pkg::CSR_SUBST_DEFAULT};
      next_st.start = cfg_start;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      st <= '{run_q: 1'b0, stop_ev: 1'b0, run_ev: 1'b0,
              react: {csr_pkg::CSR_REACT_DEFAULT, csr_pkg::CSR_REACT_DEFAULT},
              subst: {csr_pkg::CSR_SUBST_DEFAULT, csr_pkg::CSR_SUBST_DEFAULT},
              start: {csr_pkg::CSR_START_DEFAULT, csr_pkg::CSR_START_DEFAULT},
              in_b: csr_pkg::CSR_IN_BYTES, out_b: csr_pkg::CSR_OUT_BYTES_STD, ack: 1'b0};
    else
      st <= next_st;
  end
  assign in_bytes = st.in_b;
  assign out_bytes = st.out_b;
  assign rec_ack = st.ack;
  genvar g;
  generate
    for (g = 0; g < csr_pkg::CSR_CHANNELS; g++)
    begin : ch
      csr_channel u_ch
      (
        .clk_sys(clk_sys),
        .reset(reset),
        .stop_entry(st.stop_ev),
        .run_entry(st.run_ev),
        .cpu_stopped(!st.run_q),
        .reaction(st.react[2*g +: 2]),
        .subst_val(st.subst[2*g +: 2]),
        .start_val(st.start[32*g +: 32]),
        .count_up(count_up[g]),
        .count_dn(count_dn[g]),
        .cmp_val(cmp_val[32*g +: 32]),
        .prog_dq(prog_dq[2*g +: 2]),
        .dq_by_cmp(dq_by_cmp[2*g +: 2]),
        .dq(dq[2*g +: 2]),
        .count(count[32*g +: 32])
      );
    end
  endgenerate
  stop_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
    st.stop_ev |=> !st.stop_ev)
    else $error("stop event longer than one cycle");
  stop_edge_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(cpu_run) |=> st.stop_ev)
    else $error("stop entry missed");
  img_size_a: assert property (@(posedge clk_sys) disable iff (reset)
    motion_mode |=> out_bytes == csr_pkg::CSR_OUT_BYTES_MC && in_bytes == csr_pkg::CSR_IN_BYTES)
    else $error("motion image size wrong");
  img_std_a: assert property (@(posedge clk_sys) disable iff (reset)
    !motion_mode |=> out_bytes == csr_pkg::CSR_OUT_BYTES_STD)
    else $error("standard image size wrong");
  rec_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    rec_wr && rec_num == csr_pkg::CSR_RECORD_PARAM |=> rec_ack && st.react == $past(rec_react))
    else $error("record not applied");
  rec_other_a: assert property (@(posedge clk_sys) disable iff (reset)
    rec_wr && rec_num != csr_pkg::CSR_RECORD_PARAM |=> !rec_ack)
    else $error("foreign record acknowledged");
  dflt_a: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_load && !cfg_full && !rec_wr
    |=> st.react == {csr_pkg::CSR_REACT_DEFAULT, csr_pkg::CSR_REACT_DEFAULT}
    && st.subst == {csr_pkg::CSR_SUBST_DEFAULT, csr_pkg::CSR_SUBST_DEFAULT})
    else $error("defaults not applied");
  chan_sep_a: assert property (@(posedge clk_sys) disable iff (reset)
    rec_wr && rec_num == csr_pkg::CSR_RECORD_PARAM |=> st.react[3:2] == $past(rec_react[3:2]))
    else $error("channel reaction not separate");
  run_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
    st.run_ev |=> !st.run_ev)
    else $error("run event longer than one cycle");
  run_edge_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(cpu_run) |=> st.run_ev)
    else $error("run entry missed");
  stop_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    !st.run_q || cpu_run |=> !st.stop_ev)
    else $error("stop event without stop entry");
  rec_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    !rec_wr |=> !rec_ack)
    else $error("acknowledge without record write");
  rec_wins_a: assert property (@(posedge clk_sys) disable iff (reset)
    rec_wr && rec_num == csr_pkg::CSR_RECORD_PARAM
    |=> st.subst == $past(rec_subst) && st.start == $past(rec_start))
    else $error("record values not taken");
  full_cfg_a: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_load && cfg_full && !rec_wr |=> st.react == $past(cfg_react))
    else $error("configured reactions not taken");
  keep_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
    !rec_wr && !cfg_load |=> $stable(st.react) && $stable(st.subst))
    else $error("reaction selection changed without load");
  in_size_a: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> in_bytes == csr_pkg::CSR_IN_BYTES)
    else $error("input image size wrong");
  generate
    for (g = 0; g < csr_pkg::CSR_CHANNELS; g++)
    begin : chk
      stop_subst_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.stop_ev && st.react[2*g +: 2] == csr_pkg::CSR_REACT_SUBST
        |=> dq[2*g +: 2] == $past(st.subst[2*g +: 2]))
        else $error("substitute value missing at stop");
      stop_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.stop_ev && st.react[2*g +: 2] == csr_pkg::CSR_REACT_HOLD
        |=> $stable(dq[2*g +: 2]))
        else $error("output not held at stop");
      run_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.run_ev && st.react[2*g +: 2] == csr_pkg::CSR_REACT_CONT
        && !count_up[g] && !count_dn[g] |=> $stable(count[32*g +: 32]))
        else $error("counter reloaded in continue mode");
      restart_out_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.run_ev && st.react[2*g +: 2] != csr_pkg::CSR_REACT_CONT && !dq_by_cmp[2*g]
        |=> dq[2*g] == $past(prog_dq[2*g]))
        else $error("output not resumed at restart");
    end
  endgenerate
  stop_c: cover property (@(posedge clk_sys) st.stop_ev);
  run_c: cover property (@(posedge clk_sys) st.run_ev);
  rec_c: cover property (@(posedge clk_sys) rec_ack);
  mc_c: cover property (@(posedge clk_sys) motion_mode ##1 out_bytes == csr_pkg::CSR_OUT_BYTES_MC);
  hold_c: cover property (@(posedge clk_sys) st.stop_ev && st.react[3:2] == csr_pkg::CSR_REACT_HOLD);
endmodule

// ---- verification/csr_cpu_model.sv ----
// Controlling CPU model: run/stop status and parameter record writes
`timescale 1ns/10ps
module csr_cpu_model
(
  input wire logic clk_sys,
  input wire logic want_run,
  input wire logic want_wr,
  input wire logic [7:0] want_num,
  output logic cpu_run,
  output logic rec_wr,
  output logic [7:0] rec_num
);
  logic run_s = 1'b0;
  logic wr_s = 1'b0;
  logic [7:0] num_s = 8'h00;
  // Requests taken at the rising edge, clear of the bench's falling-edge updates
  always @(posedge clk_sys)
  begin
    run_s <= want_run;
    wr_s <= want_wr;
    num_s <= want_wr ? want_num : ~num_s;
  end
  // Status and record strobe change only between sampling edges
  always @(negedge clk_sys)
  begin
    cpu_run <= run_s;
    rec_wr <= wr_s;
    rec_num <= num_s;
  end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the stop reaction block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  typedef struct {logic mm; logic [3:0] bc; logic [3:0] pd; logic [3:0] edq; logic [4:0] eo;}
    csr_row_t;
  logic clk_sys = 1'b0, reset = 1'b1, motion_mode = 1'b0, cfg_load = 1'b0, cfg_full = 1'b1;
  logic want_run = 1'b0, want_wr = 1'b0, cpu_run, rec_wr, rec_ack;
  logic [7:0] want_num = 8'h00, rec_num;
  logic [3:0] cfg_react = 4'h0, cfg_subst = 4'h0, rec_react = 4'h0, rec_subst = 4'h0;
  logic [3:0] prog_dq = 4'h0, dq_by_cmp = 4'h0, dq;
  logic [63:0] cfg_start = 64'h0, rec_start = 64'h0, cmp_val = {32'h0, 32'h10}, count;
  logic [1:0] count_up = 2'h0, count_dn = 2'h0;
  logic [4:0] in_bytes, out_bytes;
  int num_errors = 0, n_compared = 0, acks = 0;
  csr_row_t rows[3] = '{'{1'b0, 4'h0, 4'h3, 4'h3, 5'h0C}, '{1'b1, 4'h0, 4'hC, 4'hC, 5'h04},
    '{1'b0, 4'h3, 4'h0, 4'h1, 5'h0C}};
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  csr_cpu_model cpu_u (.clk_sys(clk_sys), .want_run(want_run), .want_wr(want_wr),
    .want_num(want_num), .cpu_run(cpu_run), .rec_wr(rec_wr), .rec_num(rec_num));
  csr_top dut_u (.clk_sys(clk_sys), .reset(reset), .cpu_run(cpu_run),
    .motion_mode(motion_mode), .cfg_load(cfg_load), .cfg_full(cfg_full), .cfg_react(cfg_react),
    .cfg_subst(cfg_subst), .cfg_start(cfg_start), .rec_wr(rec_wr), .rec_num(rec_num),
    .rec_react(rec_react), .rec_subst(rec_subst), .rec_start(rec_start), .count_up(count_up),
    .count_dn(count_dn), .cmp_val(cmp_val), .prog_dq(prog_dq), .dq_by_cmp(dq_by_cmp), .dq(dq),
    .count(count), .in_bytes(in_bytes), .out_bytes(out_bytes), .rec_ack(rec_ack));
  always @(negedge clk_sys)
  begin
    if (rec_ack === 1'b1)
      acks++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] num);
    want_num = num;
    want_wr = 1'b1;
    cyc(1);
    want_wr = 1'b0;
  endtask
  task automatic load_cfg(input logic full);
    cfg_full = full;
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    cyc(1);
    reset = 1'b0;
    cyc(1);
    `CHK("reset dq", 4'h0, dq)
    `CHK("reset out_bytes", csr_pkg::CSR_OUT_BYTES_STD, out_bytes)
    $display("reset test done");
    cfg_react = {csr_pkg::CSR_REACT_HOLD, csr_pkg::CSR_REACT_SUBST};
    cfg_subst = 4'h1;
    cfg_start = {32'h20, 32'h10};
    load_cfg(1'b1);
    want_run = 1'b1;
    cyc(5);
    `CHK("start count", {32'h20, 32'h10}, count)
    foreach (rows[i])
    begin
      motion_mode = rows[i].mm;
      dq_by_cmp = rows[i].bc;
      prog_dq = rows[i].pd;
      cyc(3);
      `CHK("row dq", rows[i].edq, dq)
      `CHK("row in_bytes", csr_pkg::CSR_IN_BYTES, in_bytes)
      `CHK("row out_bytes", rows[i].eo, out_bytes)
    end
    $display("table test done");
    dq_by_cmp = 4'h0;
    prog_dq = 4'hA;
    count_up = 2'h3;
    cyc(3);
    count_up = 2'h0;
    want_run = 1'b0;
    cyc(5);
    prog_dq = 4'h5;
    cyc(3);
    `CHK("stop dq", 4'h9, dq)
    want_run = 1'b1;
    cyc(5);
    `CHK("restart count", {32'h20, 32'h10}, count)
    `CHK("restart dq", 4'h5, dq)
    $display("stop test done");
    rec_react = {csr_pkg::CSR_REACT_CONT, csr_pkg::CSR_REACT_CONT};
    wr(8'h7F);
    cyc(4);
    `CHK("foreign record", 0, acks)
    wr(8'h80);
    cyc(4);
    `CHK("record ack", 1, acks)
    want_run = 1'b0;
    cyc(5);
    count_up = 2'h1;
    prog_dq = 4'h6;
    cyc(3);
    count_dn = 2'h3;
    cyc(1);
    count_up = 2'h0;
    count_dn = 2'h0;
    cyc(2);
    `CHK("down count", 32'h1F, count[63:32])
    `CHK("continue dq", 4'h6, dq)
    `CHK("continue count", 32'h13, count[31:0])
    $display("continue test done");
    want_run = 1'b1;
    cyc(5);
    load_cfg(1'b0);
    prog_dq = 4'hF;
    cyc(3);
    want_run = 1'b0;
    cyc(5);
    `CHK("default dq", 4'h0, dq)
    $display("default test done");
    report_and_stop();
  end
endmodule
